// file: rtl/vic_core.sv
// Vectored interrupt controller: request/enable flags, priority, vectors,
// three-level context stack, edge and zero-cross selection, standby guard.
// Assumes CPU strobes are one-cycle pulses synchronous to clk.
`default_nettype none
module vic_core (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   // Request sources
   input  wire logic                           ext_pin,
   input  wire logic                           zero_cross_out,
   input  wire logic                           timer_zero_match,
   input  wire logic                           timer_one_match,
   input  wire logic                           interval_overflow,
   input  wire logic                           serial_transfer_end,
   // Conditioned pin to timer zero and interval timer count inputs
   output logic                                count_pulse,
   // Register-file access from the CPU
   input  wire logic                           rf_write,
   input  wire logic [6:0]                     rf_addr,
   input  wire logic [3:0]                     rf_wdata,
   output logic      [3:0]                     rf_rdata,
   output logic                                rf_hit,
   // CPU instruction strobes
   input  wire logic                           enable_interrupts_instr,
   input  wire logic                           disable_interrupts_instr,
   input  wire logic                           return_instr,
   input  wire logic                           halt_instr,
   input  wire logic                           stop_instr,
   input  wire logic [3:0]                     standby_cond,
   input  wire logic                           cpu_ready,
   // Context to save on entry
   input  wire logic [vic_pkg::CTX_WIDTH-1:0]  ctx_in,
   output logic      [vic_pkg::CTX_WIDTH-1:0]  ctx_out,
   output logic                                ctx_restore,
   // Interrupt entry to the CPU
   output logic                                irq_take,
   output logic      [10:0]                    irq_vector,
   output logic      [1:0]                     nest_level,
   // Standby state
   output logic                                halt_mode,
   output logic                                stop_mode,
   output logic                                standby_release
);
   typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP} vic_mode_type;

   logic [4:0]                    req_q;
   logic [4:0]                    req_set;
   logic [4:0]                    req_clr;
   logic [4:0]                    en_q;
   logic                          global_irq_enable_q;
   logic [1:0]                    edge_sel_q;
   logic                          zero_cross_select_q;
   logic                          pin_sel;
   logic                          pin_q;
   logic                          pin_rise;
   logic                          pin_fall;
   logic                          pin_edge;
   logic [4:0]                    armed;
   logic [4:0]                    grant;
   logic                          take;
   logic [1:0]                    depth_q;
   logic [vic_pkg::CTX_WIDTH-1:0] stack_q [vic_pkg::STACK_DEPTH];
   logic [1:0]                    pop_idx;
   vic_mode_type                  mode_q;
   logic [3:0]                    cond_q;
   logic [4:0]                    rel_mask;
   logic                          release_now;
   logic                          block_standby;

   assign pin_sel     = zero_cross_select_q ? zero_cross_out : ext_pin;
   assign count_pulse = pin_sel;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_sel;
      end
   end

   assign pin_rise = pin_sel & ~pin_q;
   assign pin_fall = ~pin_sel & pin_q;
   always_comb begin
      case (edge_sel_q)
         vic_pkg::EDGE_RISE: pin_edge = pin_rise;
         vic_pkg::EDGE_FALL: pin_edge = pin_fall;
         default:            pin_edge = pin_rise | pin_fall;
      endcase
   end

   assign req_set = {serial_transfer_end, interval_overflow, timer_one_match,
                     timer_zero_match, pin_edge};

   // Only the highest-priority armed source may win
   assign armed = req_q & en_q;
   always_comb begin
      grant = 5'h00;
      for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (armed[i]) begin
            grant = 5'h00;
            grant[i] = 1'b1;
         end
      end
   end

   // Full stack refuses further nesting rather than overwriting context
   assign take = global_irq_enable_q && (armed != 5'h00) && cpu_ready && mode_q == ST_RUN
                 && depth_q < 2'(vic_pkg::STACK_DEPTH);

   genvar g;
   generate
      for (g = 0; g < vic_pkg::NUM_SRC; g++) begin : g_req
         localparam logic [6:0] ADDR = vic_pkg::ADDR_EXT_REQ - 7'(g);
         assign req_clr[g] = (take && grant[g]) ||
                             (rf_write && rf_addr == ADDR && !rf_wdata[0]);
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               req_q[g] <= vic_pkg::REQ_RESET[g];
            end else if (req_set[g]) begin
               req_q[g] <= 1'b1;
            end else if (rf_write && rf_addr == ADDR && rf_wdata[0]) begin
               req_q[g] <= 1'b1;
            end else if (req_clr[g]) begin
               req_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_q                <= vic_pkg::EN_RESET;
         edge_sel_q          <= vic_pkg::EDGE_RESET;
         zero_cross_select_q <= 1'b0;
      end else if (rf_write) begin
         case (rf_addr)
            vic_pkg::ADDR_ENABLES:  en_q[3:0]           <= rf_wdata;
            vic_pkg::ADDR_SER_EN:   en_q[4]             <= rf_wdata[0];
            vic_pkg::ADDR_EDGE_SEL: edge_sel_q          <= rf_wdata[1:0];
            vic_pkg::ADDR_ZERO_CROSS_SELECT:   zero_cross_select_q <= rf_wdata[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         global_irq_enable_q <= 1'b0;
      end else if (disable_interrupts_instr) begin
         global_irq_enable_q <= 1'b0;
      end else if (enable_interrupts_instr) begin
         global_irq_enable_q <= 1'b1;
      end
   end

   // Global enable deliberately has no read path
   always_comb begin
      rf_hit   = 1'b1;
      rf_rdata = 4'h0;
      case (rf_addr)
         vic_pkg::ADDR_EXT_REQ:  rf_rdata = {3'h0, req_q[0]};
         vic_pkg::ADDR_TM0_REQ:  rf_rdata = {3'h0, req_q[1]};
         vic_pkg::ADDR_TM1_REQ:  rf_rdata = {3'h0, req_q[2]};
         vic_pkg::ADDR_BTM_REQ:  rf_rdata = {3'h0, req_q[3]};
         vic_pkg::ADDR_SER_REQ:  rf_rdata = {3'h0, req_q[4]};
         vic_pkg::ADDR_ENABLES:  rf_rdata = en_q[3:0];
         vic_pkg::ADDR_SER_EN:   rf_rdata = {3'h0, en_q[4]};
         vic_pkg::ADDR_EDGE_SEL: rf_rdata = {2'h0, edge_sel_q};
         vic_pkg::ADDR_ZERO_CROSS_SELECT:   rf_rdata = {3'h0, zero_cross_select_q};
         default:                rf_hit   = 1'b0;
      endcase
   end

   // Context stack
   assign pop_idx = depth_q - 2'd1;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         depth_q <= 2'd0;
      end else if (take) begin
         depth_q <= depth_q + 2'd1;
      end else if (return_instr && depth_q != 2'd0) begin
         depth_q <= depth_q - 2'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < vic_pkg::STACK_DEPTH; i++) begin
            stack_q[i] <= '0;
         end
      end else if (take) begin
         stack_q[depth_q] <= ctx_in;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctx_out     <= '0;
         ctx_restore <= 1'b0;
      end else begin
         ctx_restore <= return_instr && depth_q != 2'd0 && !take;
         if (return_instr && depth_q != 2'd0 && !take) begin
            ctx_out <= stack_q[pop_idx];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_take   <= 1'b0;
         irq_vector <= 11'h000;
      end else begin
         irq_take <= take;
         if (take) begin
            case (1'b1)
               grant[vic_pkg::SRC_EXT]: irq_vector <= vic_pkg::VEC_EXT;
               grant[vic_pkg::SRC_TM0]: irq_vector <= vic_pkg::VEC_TM0;
               grant[vic_pkg::SRC_TM1]: irq_vector <= vic_pkg::VEC_TM1;
               grant[vic_pkg::SRC_BTM]: irq_vector <= vic_pkg::VEC_BTM;
               default:                 irq_vector <= vic_pkg::VEC_SER;
            endcase
         end
      end
   end
   assign nest_level = depth_q;

   always_comb begin
      block_standby = (req_q & (standby_cond[3] ? en_q : 5'h00)) != 5'h00;
      if (halt_instr && standby_cond[1] && req_q[vic_pkg::SRC_TM1]) begin
         block_standby = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cond_q <= 4'h0;
      end else if ((halt_instr || stop_instr) && mode_q == ST_RUN) begin
         cond_q <= standby_cond;
      end
   end

   // Latched operand: bit 3 permits enabled sources, bit 1 forces timer one (halt only)
   always_comb begin
      rel_mask = cond_q[3] ? en_q : 5'h00;
      if (mode_q == ST_HALT && cond_q[1]) begin
         rel_mask[vic_pkg::SRC_TM1] = 1'b1;
      end
      if (mode_q == ST_STOP && !cond_q[3]) begin
         rel_mask = 5'h00;
      end
   end

   assign release_now = (req_q & rel_mask) != 5'h00;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q <= ST_RUN;
      end else begin
         case (mode_q)
            ST_RUN: begin
               if (halt_instr && !block_standby) begin
                  mode_q <= ST_HALT;
               end else if (stop_instr && !block_standby) begin
                  mode_q <= ST_STOP;
               end
            end
            // On release, take path resumes in ST_RUN: vector if enabled, else next instruction
            ST_HALT, ST_STOP: begin
               if (release_now) begin
                  mode_q <= ST_RUN;
               end
            end
            default: mode_q <= ST_RUN;
         endcase
      end
   end

   assign halt_mode       = mode_q == ST_HALT;
   assign stop_mode       = mode_q == ST_STOP;
   assign standby_release = (mode_q != ST_RUN) && release_now;
endmodule : vic_core
`default_nettype wire

// file: rtl/vic_pkg.sv
// Constants for the vectored interrupt controller.
// Assumes a single clock and synchronous active-high reset.
`default_nettype none
package vic_pkg;
   localparam int          NUM_SRC        = 5;
   localparam int          STACK_DEPTH    = 3;
   localparam int          CTX_WIDTH      = 10;
   // Register-file addresses of the flags and select fields
   localparam logic [6:0]  ADDR_EXT_REQ   = 7'h3f;
   localparam logic [6:0]  ADDR_TM0_REQ   = 7'h3e;
   localparam logic [6:0]  ADDR_TM1_REQ   = 7'h3d;
   localparam logic [6:0]  ADDR_BTM_REQ   = 7'h3c;
   localparam logic [6:0]  ADDR_SER_REQ   = 7'h3b;
   localparam logic [6:0]  ADDR_ENABLES   = 7'h2f;
   localparam logic [6:0]  ADDR_SER_EN    = 7'h2e;
   localparam logic [6:0]  ADDR_EDGE_SEL  = 7'h1f;
   localparam logic [6:0]  ADDR_ZERO_CROSS_SELECT    = 7'h1d;
   // Source index: 0 = external pin (highest) .. 4 = serial (lowest)
   localparam int          SRC_EXT        = 0;
   localparam int          SRC_TM0        = 1;
   localparam int          SRC_TM1        = 2;
   localparam int          SRC_BTM        = 3;
   localparam int          SRC_SER        = 4;
   localparam logic [10:0] VEC_EXT        = 11'h005;
   localparam logic [10:0] VEC_TM0        = 11'h004;
   localparam logic [10:0] VEC_TM1        = 11'h003;
   localparam logic [10:0] VEC_BTM        = 11'h002;
   localparam logic [10:0] VEC_SER        = 11'h001;
   localparam logic [4:0]  REQ_RESET      = 5'h04;
   localparam logic [4:0]  EN_RESET       = 5'h00;
   localparam logic [1:0]  EDGE_RESET     = 2'h0;
   localparam logic [1:0]  EDGE_RISE      = 2'h0;
   localparam logic [1:0]  EDGE_FALL      = 2'h1;
endpackage : vic_pkg
`default_nettype wire

// file: verif/tb_vectored_interrupt_control.sv
// Bench for vic_core: flags, priority, nesting, edges, standby.
// Assumes vic_periph_model and the bound checker.
`default_nettype none
module tb_vectored_interrupt_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, ext_pin, zero_cross_out, rf_write, cpu_ready, rf_hit, count_pulse, ctx_restore;
   logic irq_take, halt_mode, stop_mode, standby_release;
   logic [6:0] rf_addr;
   logic [3:0] rf_wdata, rf_rdata, standby_cond, fire, ev;
   logic [4:0] ins;
   logic [9:0] ctx_in, ctx_out;
   logic [10:0] irq_vector;
   logic [1:0] nest_level;
   int num_errors = 0, n_checks = 0;
   vic_core i_vic_core (.clk(clk), .sys_rst(sys_rst), .ext_pin(ext_pin), .zero_cross_out(zero_cross_out),
      .timer_zero_match(ev[0]), .timer_one_match(ev[1]), .interval_overflow(ev[2]),
      .serial_transfer_end(ev[3]), .count_pulse(count_pulse), .rf_write(rf_write), .rf_addr(rf_addr),
      .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .rf_hit(rf_hit), .enable_interrupts_instr(ins[0]),
      .disable_interrupts_instr(ins[1]), .return_instr(ins[2]), .halt_instr(ins[3]), .stop_instr(ins[4]),
      .standby_cond(standby_cond), .cpu_ready(cpu_ready), .ctx_in(ctx_in), .ctx_out(ctx_out),
      .ctx_restore(ctx_restore), .irq_take(irq_take), .irq_vector(irq_vector), .nest_level(nest_level),
      .halt_mode(halt_mode), .stop_mode(stop_mode), .standby_release(standby_release));
   vic_periph_model i_vic_periph_model (.clk(clk), .fire(fire), .nest_level(nest_level), .events_q(ev),
      .ctx_in(ctx_in));
   task automatic test_done;
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [6:0] a, input logic [3:0] d);
      rf_addr = a;
      rf_wdata = d;
      rf_write = 1'b1;
      tick(1);
      rf_write = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [3:0] m, input logic [3:0] e, input logic h = 1'b1);
      rf_addr = a;
      #1;
      chk({6'h00, rf_hit, rf_rdata & m}, {6'h00, h, e});
      tick(1);
   endtask : rd
   task automatic op(input int i);
      ins[i] = 1'b1;
      tick(1);
      ins = 5'h00;
      tick(1);
   endtask : op
   task automatic shoot(input int i);
      fire[i] = 1'b1;
      tick(1);
      fire = 4'h0;
   endtask : shoot
   task automatic none(input int n);
      repeat (n) begin
         tick(1);
         chk({10'h000, irq_take}, 11'h000);
      end
   endtask : none
   // Bounded wait; a missing entry ends the run
   task automatic take(input logic [10:0] v);
      int k;
      for (k = 0; k < 20 && irq_take !== 1'b1; k++) tick(1);
      if (k == 20) begin
         num_errors++;
         $display("Error at %0t: no entry", $time);
         test_done();
      end
      chk(irq_vector, v);
      tick(1);
   endtask : take
   // Restore pulse stands one cycle, so it is checked before the idle cycle
   task automatic ret(input logic [9:0] c, input logic r = 1'b1);
      ins[2] = 1'b1;
      tick(1);
      ins = 5'h00;
      chk({10'h000, ctx_restore}, {10'h000, r});
      if (r) begin
         chk({1'b0, ctx_out}, {1'b0, c});
      end
      tick(1);
   endtask : ret
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      {sys_rst, ext_pin, zero_cross_out, rf_write, cpu_ready} = 5'h11;
      rf_addr = 7'h3d;
      {rf_wdata, standby_cond, fire, ins} = 17'h00000;
      tick(10);
      sys_rst = 1'b0;
      rd(7'h3d, 4'h1, 4'h1);
      for (int i = 0; i < 5; i++) rd(7'h3f - 7'(i), 4'h1, {3'h0, i == 2});
      rd(7'h2f, 4'hf, 4'h0);
      rd(7'h2e, 4'h1, 4'h0);
      rd(7'h10, 4'hf, 4'h0, 1'b0);
      wr(7'h3d, 4'h0);
      rd(7'h3d, 4'h1, 4'h0);
      wr(7'h3e, 4'h1);
      rd(7'h3e, 4'h1, 4'h1);
      op(0);
      none(4);
      wr(7'h2f, 4'h2);
      take(11'h004);
      rd(7'h3e, 4'h1, 4'h0);
      ret(10'h155);
      ret(10'h000, 1'b0);
      op(1);
      shoot(0);
      none(4);
      rd(7'h3e, 4'h1, 4'h1);
      ins = 5'h03;
      none(4);
      ins = 5'h00;
      wr(7'h3e, 4'h0);
      // All five pending: three nest, the rest wait for returns
      wr(7'h2f, 4'hf);
      wr(7'h2e, 4'h1);
      for (int i = 0; i < 5; i++) wr(7'h3f - 7'(i), 4'h1);
      op(0);
      for (int i = 0; i < 3; i++) take(11'h005 - 11'(i));
      none(4);
      chk({9'h000, nest_level}, 11'h003);
      cpu_ready = 1'b0;
      ret(10'h157);
      ret(10'h154);
      ret(10'h155);
      cpu_ready = 1'b1;
      take(11'h002);
      take(11'h001);
      ret(10'h154);
      ret(10'h155);
      rd(7'h3b, 4'h1, 4'h0);
      op(1);
      for (int m = 0; m < 4; m++) begin
         wr(7'h1f, 4'(m));
         repeat (2) begin
            ext_pin = ~ext_pin;
            tick(3);
            rd(7'h3f, 4'h1, {3'h0, (m == 0 && ext_pin) || (m == 1 && !ext_pin) || m >= 2});
            wr(7'h3f, 4'h0);
         end
      end
      wr(7'h1d, 4'h1);
      zero_cross_out = 1'b1;
      tick(3);
      chk({10'h000, count_pulse}, 11'h001);
      rd(7'h3f, 4'h1, 4'h1);
      {ext_pin, zero_cross_out} = 2'h2;
      tick(1);
      chk({10'h000, count_pulse}, 11'h000);
      wr(7'h1d, 4'h0);
      chk({10'h000, count_pulse}, 11'h001);
      tick(2);
      wr(7'h3f, 4'h0);
      wr(7'h2f, 4'h2);
      wr(7'h2e, 4'h0);
      standby_cond = 4'h8;
      op(3);
      chk({10'h000, halt_mode}, 11'h001);
      shoot(0);
      none(4);
      chk({10'h000, halt_mode}, 11'h000);
      op(3);
      chk({10'h000, halt_mode}, 11'h000);
      op(4);
      chk({10'h000, stop_mode}, 11'h000);
      wr(7'h3e, 4'h0);
      op(0);
      op(4);
      chk({10'h000, stop_mode}, 11'h001);
      shoot(0);
      take(11'h004);
      chk({10'h000, stop_mode}, 11'h000);
      ret(10'h155);
      test_done();
   end
endmodule : tb_vectored_interrupt_control
`default_nettype wire

// file: verif/vic_core_monitor.sv
// Port checker for vic_core.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module vic_core_monitor (
   // Clock, reset and strobes
   input wire logic        clk, sys_rst, ext_pin, zero_cross_out, rf_write, return_instr,
   input wire logic        enable_interrupts_instr, disable_interrupts_instr, count_pulse,
   // Entry, return and standby
   input wire logic        ctx_restore, irq_take, halt_mode, stop_mode, standby_release,
   input wire logic [6:0]  rf_addr,
   input wire logic [3:0]  rf_rdata,
   input wire logic [10:0] irq_vector,
   input wire logic [1:0]  nest_level
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rst; $past(sys_rst) |-> !irq_take && nest_level == 2'h0 && !halt_mode && !stop_mode; endproperty
   a_rst: assert property (p_rst) else $error("state after reset");
   property p_tm1; $past(sys_rst) && rf_addr == 7'h3d |-> rf_rdata[0]; endproperty
   a_tm1: assert property (p_tm1) else $error("timer one flag after reset");
   property p_nest; irq_take |-> nest_level == $past(nest_level) + 2'h1; endproperty
   a_nest: assert property (p_nest) else $error("depth on entry");
   property p_cap; nest_level == 2'h3 |=> !irq_take; endproperty
   a_cap: assert property (p_cap) else $error("entry beyond depth");
   property p_pop; ctx_restore |-> nest_level == $past(nest_level) - 2'h1; endproperty
   a_pop: assert property (p_pop) else $error("depth on return");
   property p_empty; return_instr && nest_level == 2'h0 |=> !ctx_restore; endproperty
   a_empty: assert property (p_empty) else $error("pop when empty");
   // Reset clears the vector, so the edge after reset is left out
   property p_vec; !irq_take && !$past(sys_rst) |-> $stable(irq_vector); endproperty
   a_vec: assert property (p_vec) else $error("vector moved");
   property p_di; disable_interrupts_instr ##1 !enable_interrupts_instr |=> !irq_take; endproperty
   a_di: assert property (p_di) else $error("entry after disable");
   property p_cnt; count_pulse != $past(count_pulse) |-> ext_pin != $past(ext_pin)
      || zero_cross_out != $past(zero_cross_out) || $past(rf_write); endproperty
   a_cnt: assert property (p_cnt) else $error("count pulse without cause");
   property p_rel; standby_release |=> !halt_mode && !stop_mode; endproperty
   a_rel: assert property (p_rel) else $error("standby kept after release");
   c_deep: cover property (irq_take && nest_level == 2'h3);
   c_pop: cover property (ctx_restore);
   c_rel: cover property (standby_release);
endmodule : vic_core_monitor
bind vic_core vic_core_monitor i_vic_core_monitor (.*);
`default_nettype wire

// file: verif/vic_periph_model.sv
// Stand-in for the timers, serial unit and CPU context.
// Assumes the bench raises fire bits for one cycle.
`default_nettype none
module vic_periph_model (
   input  wire logic       clk,
   input  wire logic [3:0] fire,
   input  wire logic [1:0] nest_level,
   output logic      [3:0] events_q,
   output logic      [9:0] ctx_in
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk) begin
      events_q <= fire;
   end
   // Context differs per level so a wrong pop shows
   // Buffer and window are left to handler code, so they are not in ctx_in
   assign ctx_in = 10'h155 ^ {8'h00, nest_level};
endmodule : vic_periph_model
`default_nettype wire
